// File: core/pgt_map.svh
// Register offsets, control field positions, reset values and prescale counts
// for the paired timer. Assumes a 32-bit Wishbone word per register.
`ifndef PGT_MAP_SVH
`define PGT_MAP_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define PGT_OFS_LO_CNT 8'h00
`define PGT_OFS_HOLD 8'h04
`define PGT_OFS_HI_CNT 8'h08
`define PGT_OFS_LO_PER 8'h0C
`define PGT_OFS_HI_PER 8'h10
`define PGT_OFS_LO_CTL 8'h14
`define PGT_OFS_HI_CTL 8'h18
`define PGT_OFS_FLAGS 8'h1C
`define PGT_OFS_IRQEN 8'h20

// ********************************************************
// Control fields and reset values
// ********************************************************
`define PGT_BIT_RUN 15
`define PGT_BIT_IDLE 13
`define PGT_BIT_GATE 6
`define PGT_BIT_PS_HI 5
`define PGT_BIT_PS_LO 4
`define PGT_BIT_WIDE 3
`define PGT_BIT_CS 1
`define PGT_LO_CTL_MASK 16'hA07A
`define PGT_HI_CTL_MASK 16'hA072
`define PGT_CTL_RST 16'h0000
`define PGT_PER_RST 16'hFFFF
`define PGT_CNT_RST 16'h0000
`define PGT_FLG_LO 0
`define PGT_FLG_HI 1

// ********************************************************
// Prescaler terminal counts (ratio minus one)
// ********************************************************
`define PGT_TC_DIV1 8'h00
`define PGT_TC_DIV8 8'h07
`define PGT_TC_DIV64 8'h3F
`define PGT_TC_DIV256 8'hFF

`endif

// File: core/pgt_pkg.sv
// Types shared by the paired timer modules.
// Assumes nothing of its surroundings.
package pgt_pkg;

    // Prescale ratio selection
    typedef enum logic [1:0] {
        PGT_DIV1 = 2'h0,
        PGT_DIV8 = 2'h1,
        PGT_DIV64 = 2'h2,
        PGT_DIV256 = 2'h3
    } pgt_prescale_t;

endpackage : pgt_pkg

// File: core/pgt_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pin_i is asynchronous to clk_i.
module pgt_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // Chain; only s2 reads s1, so metastability stays in stage one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            level_r <= 1'b0;
        else if (s2_r == s3_r)
            level_r <= s3_r;
    end

    assign level_o = level_r;

endmodule : pgt_pin_sync

// File: core/pgt_prescale.sv
// Prescaler counter for one timer half.
// Assumes tick_i is a count enable in the clk_i domain; each cycle it is high counts once.
`include "pgt_map.svh"
module pgt_prescale #(
    parameter int PS_W = 8,
    parameter bit SYNC_OUT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic clear_i,
    input wire pgt_pkg::pgt_prescale_t sel_i,
    output logic pulse_o
);

    logic [PS_W-1:0] cnt_r;
    logic [PS_W-1:0] term;
    logic hit;
    logic pulse_r;

    // Counter must hold the largest ratio
    if (PS_W < 8)
    begin : g_chk
        $error("pgt_prescale: PS_W below 8");
    end

    // Terminal count per ratio
    always_comb
    begin
        case (sel_i)
            pgt_pkg::PGT_DIV1: term = PS_W'(`PGT_TC_DIV1);
            pgt_pkg::PGT_DIV8: term = PS_W'(`PGT_TC_DIV8);
            pgt_pkg::PGT_DIV64: term = PS_W'(`PGT_TC_DIV64);
            pgt_pkg::PGT_DIV256: term = PS_W'(`PGT_TC_DIV256);
            default: term = PS_W'(`PGT_TC_DIV1);
        endcase
    end

    assign hit = tick_i & (cnt_r == term) & ~clear_i;

    // Count input ticks; a clear restarts the ratio
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
            cnt_r <= '0;
        else if (tick_i)
            cnt_r <= (cnt_r == term) ? '0 : cnt_r + 1'b1;
    end

    // Retimed output, costs one cycle of latency
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
            pulse_r <= 1'b0;
        else
            pulse_r <= hit;
    end

    // Only the lower half retimes its output
    if (SYNC_OUT)
    begin : g_sync
        assign pulse_o = pulse_r;
    end
    else
    begin : g_raw
        assign pulse_o = hit;
    end

endmodule : pgt_prescale

// File: core/pgt_timer.sv
// Paired 16-bit timer, cascadable to one 32-bit timer or counter.
// Assumes a classic Wishbone master on clk_i and asynchronous pins.
// Summary of operation
// - Split halves: timer or synchronous counter only
// - Lower half is low word
// - Wide mode uses lower control; upper run stop also clears prescaler
// - Wide interrupt through upper flag, enable
// - Only lower prescaler output is retimed
// - Wide timer counts cycles to period
// - Low word read latches high word
// - Low word write loads held high
// - Wide counter counts synchronised pin rises
// - Idle stops count when selected
// - Gate counts cycles while pin high
// - Upper half never gated
// - Gate fall stops, keeps count
// - Wide match pulses converter trigger
// - Prescale by 1, 8, 64, 256
// - Wide mode ignores upper prescaler
// - Count write or stop clears prescaler
// - Stopped prescaler ignores count write clear
// - Control writes keep counts intact
// - Sleep halts all counting
// - Upper flag sticky until software clears
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`include "pgt_map.svh"
module pgt_timer #(
    parameter int ADR_W = 8,
    parameter int PS_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic gate_clock_pin_i,
    input wire logic upper_clock_pin_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    output logic adc_trigger_o,
    output logic low_irq_o,
    output logic upper_irq_o
);

    // ********************************************************
    // Checks and declarations
    // ********************************************************
    if (ADR_W < 6)
    begin : g_chk
        $error("pgt_timer: ADR_W too small for register map");
    end

    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rdata;
    logic [15:0] low_count_word_r;
    logic [15:0] high_count_word_r;
    logic [15:0] high_word_holding_r;
    logic [15:0] low_period_word_r;
    logic [15:0] high_period_word_r;
    logic [15:0] lo_ctl_r;
    logic [15:0] hi_ctl_r;
    logic [1:0] flags_r;
    logic [1:0] irq_en_r;
    logic [1:0] run_prev_r;
    logic [1:0] pin_lvl;
    logic [1:0] pin_prev_r;
    logic [1:0] pin_rise;
    logic [1:0] ps_tick;
    logic [1:0] ps_clr;
    logic [1:0] ptick;
    pgt_pkg::pgt_prescale_t ps_sel [2];
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic acc;
    logic wr;
    logic rd;
    logic wr_lo;
    logic wr_hi;
    logic wr_hold;
    logic rd_lo;
    logic wide_mode_select;
    logic lo_run;
    logic hi_run;
    logic gate_fall;
    logic lo_match;
    logic hi_match;
    logic wide_match;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge_word(
        input logic [15:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        merge_word = {sel[1] ? new_v[15:8] : old_v[15:8],
                      sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge_word

    // ********************************************************
    // Wishbone slave
    // ********************************************************
    // One access per request; ack_r blocks a second take
    assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    assign wr_lo = wr & (wb_adr_i == ADR_W'(`PGT_OFS_LO_CNT));
    assign wr_hi = wr & (wb_adr_i == ADR_W'(`PGT_OFS_HI_CNT));
    assign wr_hold = wr & (wb_adr_i == ADR_W'(`PGT_OFS_HOLD));
    assign rd_lo = rd & (wb_adr_i == ADR_W'(`PGT_OFS_LO_CNT));

    // Read mux; unmapped words read as zero
    always_comb
    begin
        case (wb_adr_i)
            ADR_W'(`PGT_OFS_LO_CNT): rdata = {16'h0000, low_count_word_r};
            ADR_W'(`PGT_OFS_HOLD): rdata = {16'h0000, high_word_holding_r};
            ADR_W'(`PGT_OFS_HI_CNT): rdata = {16'h0000, high_count_word_r};
            ADR_W'(`PGT_OFS_LO_PER): rdata = {16'h0000, low_period_word_r};
            ADR_W'(`PGT_OFS_HI_PER): rdata = {16'h0000, high_period_word_r};
            ADR_W'(`PGT_OFS_LO_CTL): rdata = {16'h0000, lo_ctl_r};
            ADR_W'(`PGT_OFS_HI_CTL): rdata = {16'h0000, hi_ctl_r};
            ADR_W'(`PGT_OFS_FLAGS): rdata = {30'h0000_0000, flags_r};
            ADR_W'(`PGT_OFS_IRQEN): rdata = {30'h0000_0000, irq_en_r};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Answer one cycle after the request, drop the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= acc;
            if (rd)
                dat_r <= rdata;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ********************************************************
    // Control, period and enable registers
    // ********************************************************
    // Control writes touch no count register
    // counts kept
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lo_ctl_r <= `PGT_CTL_RST;
            hi_ctl_r <= `PGT_CTL_RST;
            low_period_word_r <= `PGT_PER_RST;
            high_period_word_r <= `PGT_PER_RST;
            irq_en_r <= 2'h0;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                ADR_W'(`PGT_OFS_LO_CTL):
                    lo_ctl_r <= merge_word(lo_ctl_r, wb_dat_i, wb_sel_i) & `PGT_LO_CTL_MASK;
                ADR_W'(`PGT_OFS_HI_CTL):
                    hi_ctl_r <= merge_word(hi_ctl_r, wb_dat_i, wb_sel_i) & `PGT_HI_CTL_MASK;
                ADR_W'(`PGT_OFS_LO_PER):
                    low_period_word_r <= merge_word(low_period_word_r, wb_dat_i, wb_sel_i);
                ADR_W'(`PGT_OFS_HI_PER):
                    high_period_word_r <= merge_word(high_period_word_r, wb_dat_i, wb_sel_i);
                ADR_W'(`PGT_OFS_IRQEN):
                    if (wb_sel_i[0])
                        irq_en_r <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    assign wide_mode_select = lo_ctl_r[`PGT_BIT_WIDE];
    assign lo_run = lo_ctl_r[`PGT_BIT_RUN];
    assign hi_run = hi_ctl_r[`PGT_BIT_RUN];

    // ********************************************************
    // Pins and tick sources
    // ********************************************************
    // Both pins are asynchronous, so both get the filter
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_pin
        pgt_pin_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(gi == 0 ? gate_clock_pin_i : upper_clock_pin_i),
            .level_o(pin_lvl[gi])
        );
    end

    // Edge history of the filtered levels and of the run bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_prev_r <= 2'h0;
            run_prev_r <= 2'h0;
        end
        else
        begin
            pin_prev_r <= pin_lvl;
            run_prev_r <= {hi_run, lo_run};
        end
    end

    assign pin_rise = pin_lvl & ~pin_prev_r;

    // gate fall ends accumulation, count untouched
    assign gate_fall = lo_run & lo_ctl_r[`PGT_BIT_GATE] & ~lo_ctl_r[`PGT_BIT_CS]
                       & pin_prev_r[0] & ~pin_lvl[0];

    // Lower source: pin rises, or cycles, gated by pin level
    // gated cycles
    assign ps_tick[0] = lo_run & ~cpu_sleep_i
                        & ~(cpu_idle_i & lo_ctl_r[`PGT_BIT_IDLE])
                        & (lo_ctl_r[`PGT_BIT_CS] ? pin_rise[0]
                           : (~lo_ctl_r[`PGT_BIT_GATE] | pin_lvl[0]));

    // Upper half: own setup in split mode, idle in wide mode
    // upper control ignored
    assign ps_tick[1] = hi_run & ~wide_mode_select & ~cpu_sleep_i
                        & ~(cpu_idle_i & hi_ctl_r[`PGT_BIT_IDLE])
                        & (hi_ctl_r[`PGT_BIT_CS] ? pin_rise[1] : 1'b1);

    // Clears only take while running; the stop itself also clears
    // prescaler clear
    assign ps_clr[0] = (lo_run & (wr_lo | (wide_mode_select & wr_hi)))
                       | (run_prev_r[0] & ~lo_run)
                       | (wide_mode_select & lo_run & run_prev_r[1] & ~hi_run);
    assign ps_clr[1] = (hi_run & wr_hi) | (run_prev_r[1] & ~hi_run);

    assign ps_sel[0] = pgt_pkg::pgt_prescale_t'(lo_ctl_r[`PGT_BIT_PS_HI:`PGT_BIT_PS_LO]);
    assign ps_sel[1] = pgt_pkg::pgt_prescale_t'(hi_ctl_r[`PGT_BIT_PS_HI:`PGT_BIT_PS_LO]);

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_ps
        pgt_prescale #(
            .PS_W(PS_W),
            .SYNC_OUT(gi == 0)
        ) u_ps (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(ps_tick[gi]),
            .clear_i(ps_clr[gi]),
            .sel_i(ps_sel[gi]),
            .pulse_o(ptick[gi])
        );
    end

    // ********************************************************
    // Count and holding registers
    // ********************************************************
    assign lo_match = low_count_word_r == low_period_word_r;
    assign hi_match = high_count_word_r == high_period_word_r;
    assign wide_match = lo_match & hi_match;

    // Lower word; software write beats a tick in the same cycle
    // wide period wrap
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            low_count_word_r <= `PGT_CNT_RST;
        else if (wr_lo)
            low_count_word_r <= merge_word(low_count_word_r, wb_dat_i, wb_sel_i);
        else if (ptick[0])
            low_count_word_r <= (wide_mode_select ? wide_match : lo_match)
                                ? `PGT_CNT_RST : low_count_word_r + 1'b1;
    end

    // Upper word: carry from lower in wide mode, own tick otherwise
    // upper is high word
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            high_count_word_r <= `PGT_CNT_RST;
        else if (wr_hi)
            high_count_word_r <= merge_word(high_count_word_r, wb_dat_i, wb_sel_i);
        else if (wr_lo && wide_mode_select)
            high_count_word_r <= high_word_holding_r;
        else if (wide_mode_select)
        begin
            if (ptick[0] && wide_match)
                high_count_word_r <= `PGT_CNT_RST;
            else if (ptick[0] && low_count_word_r == 16'hFFFF)
                high_count_word_r <= high_count_word_r + 1'b1;
        end
        else if (ptick[1])
            high_count_word_r <= hi_match ? `PGT_CNT_RST : high_count_word_r + 1'b1;
    end

    // Holding word is only meaningful in wide mode
    // latch on read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            high_word_holding_r <= `PGT_CNT_RST;
        else if (wr_hold)
            high_word_holding_r <= merge_word(high_word_holding_r, wb_dat_i, wb_sel_i);
        else if (rd_lo && wide_mode_select)
            high_word_holding_r <= high_count_word_r;
    end

    // ********************************************************
    // Flags, interrupt lines and converter trigger
    // ********************************************************
    // upper flag in wide mode
    assign flag_set[`PGT_FLG_LO] = ~wide_mode_select & ((ptick[0] & lo_match) | gate_fall);
    assign flag_set[`PGT_FLG_HI] = wide_mode_select
                                   ? ((ptick[0] & wide_match) | gate_fall)
                                   : (ptick[1] & hi_match);
    assign flag_clr = (wr && wb_adr_i == ADR_W'(`PGT_OFS_FLAGS) && wb_sel_i[0])
                      ? wb_dat_i[1:0] : 2'h0;

    // Write one to clear; a new event in the same cycle wins
    // sticky flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_r <= 2'h0;
        else
            flags_r <= (flags_r & ~flag_clr) | flag_set;
    end

    // Lines follow the enabled flags one cycle later
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low_irq_o <= 1'b0;
            upper_irq_o <= 1'b0;
        end
        else
        begin
            low_irq_o <= flags_r[`PGT_FLG_LO] & irq_en_r[`PGT_FLG_LO];
            upper_irq_o <= flags_r[`PGT_FLG_HI] & irq_en_r[`PGT_FLG_HI];
        end
    end

    // One-cycle trigger on a combined period match
    // converter trigger
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            adc_trigger_o <= 1'b0;
        else
            adc_trigger_o <= wide_mode_select & ptick[0] & wide_match;
    end

endmodule : pgt_timer

// File: sim/pgt_timer_monitor.sv
// Checker for the paired timer's bus answers, trigger and interrupt outputs.
// Assumes it is bound to pgt_timer and sees only that module's ports.
module pgt_timer_monitor #(
    parameter int ADR_W = 8,
    parameter int PS_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic gate_clock_pin_i,
    input wire logic upper_clock_pin_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic adc_trigger_o,
    input wire logic low_irq_o,
    input wire logic upper_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take, wr, clr, enw, wide_r, upen_r, loen_r;
    // Bus decode, so mode and enables are shadowed without peeking inside
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    assign clr = wr && wb_adr_i == ADR_W'(8'h1C) && wb_dat_i[1];
    assign enw = wr && wb_adr_i == ADR_W'(8'h20);
    // Shadow registers follow software writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wide_r <= 1'b0;
            upen_r <= 1'b0;
            loen_r <= 1'b0;
        end
        else
        begin
            if (wr && wb_adr_i == ADR_W'(8'h14))
                wide_r <= wb_dat_i[3];
            if (enw)
            begin
                loen_r <= wb_dat_i[0];
                upen_r <= wb_dat_i[1];
            end
        end
    end
    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_UNMAPPED: assert property (take && !wb_we_i && wb_adr_i == ADR_W'(8'h24)
        |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    AST_TRIG_WIDE: assert property (adc_trigger_o |-> wide_r || $past(wide_r))
        else $error("trigger outside wide mode");
    AST_LOW_SPLIT: assert property (low_irq_o |-> !$past(wide_r))
        else $error("lower irq in wide mode");
    AST_IRQ_MASK: assert property (upper_irq_o |-> $past(upen_r))
        else $error("upper irq while disabled");
    AST_TRIG_IRQ: assert property (adc_trigger_o && upen_r && !enw |=> upper_irq_o)
        else $error("match gave no upper irq");
    AST_IRQ_HOLD: assert property (upper_irq_o && !clr && !enw && !$past(clr)
        && !$past(enw) |=> upper_irq_o) else $error("upper irq dropped alone");
    AST_SLEEP_HALT: assert property (cpu_sleep_i [*6] |-> !adc_trigger_o)
        else $error("trigger during sleep");
    // Main scenarios reached
    COV_TRIG: cover property (adc_trigger_o);
    COV_LOW: cover property (low_irq_o);
    COV_UP: cover property (upper_irq_o);
endmodule : pgt_timer_monitor

bind pgt_timer pgt_timer_monitor #(.ADR_W(ADR_W), .PS_W(PS_W)) i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .gate_clock_pin_i(gate_clock_pin_i), .upper_clock_pin_i(upper_clock_pin_i),
    .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i),
    .adc_trigger_o(adc_trigger_o), .low_irq_o(low_irq_o), .upper_irq_o(upper_irq_o)
);

// File: sim/pgt_pin_src.sv
// Behavioural source for the two timer pins: gate pulses and clock bursts.
// Assumes nothing of the bench clock; its edges keep their own pace.
module pgt_pin_src (
    output logic lo_pin_o,
    output logic up_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins rest low between bursts
    initial
    begin
        lo_pin_o = 1'b0;
        up_pin_o = 1'b0;
    end
    // rising edges counted
    // Each level lasts about five clocks, above the filter's three
    task automatic burst(input bit upper, input int n);
        // Odd start offset keeps every pin change off both clock edges
        #1;
        repeat (n)
        begin
            #95;
            if (upper)
                up_pin_o = 1'b1;
            else
                lo_pin_o = 1'b1;
            #95;
            up_pin_o = 1'b0;
            lo_pin_o = 1'b0;
        end
    endtask : burst
    task automatic gate(input int span);
        #1;
        lo_pin_o = 1'b1;
        #(span);
        lo_pin_o = 1'b0;
    endtask : gate
endmodule : pgt_pin_src

// File: sim/test_pgt_timer.sv
// Self-checking bench for the paired timer: bus tasks, scenarios, verdict.
// Assumes pgt_timer, its checker and the pin source are compiled first.
module test_pgt_timer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] dout, rdat;
    logic ack, trig, lirq, uirq, gpin, upin;
    int n_fail = 0;
    int samples_checked = 0;

    pgt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .gate_clock_pin_i(gpin), .upper_clock_pin_i(upin),
        .cpu_idle_i(idle), .cpu_sleep_i(sleep), .adc_trigger_o(trig),
        .low_irq_o(lirq), .upper_irq_o(uirq));
    pgt_pin_src i_src (.lo_pin_o(gpin), .up_pin_o(upin));

    // Free-running 50 MHz clock
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; request held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (ack !== 1'b1 && t < 20);
        if (t >= 20)
            check(32'h0, 32'h1);
        rdat = dout;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rdat, e);
    endtask : rdc

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    task automatic t_reset();
        logic [7:0] a [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h24};
        logic [31:0] e [7] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0};
        wr(8'h24, 32'hFFFF);
        foreach (a[i])
            rdc(a[i], e[i]);
    endtask : t_reset

    task automatic t_wide();
        int t = 0;
        wr(8'h20, 32'h2);
        wr(8'h14, 32'h8);
        wr(8'h18, 32'h8030);
        wr(8'h04, 32'h7);
        wr(8'h00, 32'h1234);
        rdc(8'h08, 32'h7);
        wr(8'h08, 32'h9);
        wr(8'h14, 32'h18);
        rdc(8'h00, 32'h1234);
        rdc(8'h04, 32'h9);
        wr(8'h0C, 32'h3);
        wr(8'h10, 32'h2);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'hFFF0);
        wr(8'h14, 32'h8008);
        while (trig !== 1'b1 && t < 60)
        begin
            @(posedge clk_i);
            t++;
        end
        check(t inside {[17:24]}, 1'b1);
        @(posedge clk_i);
        check(trig, 1'b0);
        check(uirq, 1'b1);
        check(lirq, 1'b0);
        wr(8'h14, 32'h8);
        bus(1'b0, 8'h00, 32'h0);
        check(rdat < 32'h10, 1'b1);
        rdc(8'h04, 32'h0);
        wr(8'h20, 32'h0);
        check(uirq, 1'b0);
        rdc(8'h1C, 32'h2);
        wr(8'h1C, 32'h2);
        rdc(8'h1C, 32'h0);
        wr(8'h18, 32'h0);
    endtask : t_wide

    // every ratio over a fixed span
    task automatic t_div();
        int r [4] = '{1, 8, 64, 256};
        wr(8'h0C, 32'hFFFF);
        wr(8'h14, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h00, 32'h0);
            wr(8'h14, 32'h8000 | (s << 4));
            wait_clk(1024);
            wr(8'h14, 32'h0);
            bus(1'b0, 8'h00, 32'h0);
            check(int'(rdat) inside {[1022 / r[s]:1028 / r[s]]}, 1'b1);
        end
    endtask : t_div

    // gated accumulation, falling edge ends it
    task automatic t_gate();
        logic [31:0] n;
        wr(8'h20, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'h8040);
        i_src.gate(400);
        wait_clk(10);
        check(lirq, 1'b1);
        bus(1'b0, 8'h00, 32'h0);
        n = rdat;
        check(n inside {[17:23]}, 1'b1);
        wait_clk(40);
        rdc(8'h00, n);
        wr(8'h1C, 32'h1);
        check(lirq, 1'b0);
        wr(8'h14, 32'h0);
    endtask : t_gate

    // external clock, wide then upper split
    task automatic t_ext();
        wr(8'h10, 32'hFFFF);
        wr(8'h14, 32'h8);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'h800A);
        i_src.burst(1'b0, 10);
        wait_clk(10);
        wr(8'h14, 32'h8);
        rdc(8'h00, 32'hA);
        rdc(8'h04, 32'h0);
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h18, 32'h8002);
        i_src.burst(1'b1, 6);
        wait_clk(10);
        wr(8'h18, 32'h0);
        rdc(8'h08, 32'h6);
    endtask : t_ext

    task automatic t_idle();
        wr(8'h00, 32'h0);
        idle <= 1'b1;
        wr(8'h14, 32'hA000);
        wait_clk(20);
        rdc(8'h00, 32'h0);
        idle <= 1'b0;
        wait_clk(20);
        bus(1'b0, 8'h00, 32'h0);
        check(rdat > 32'h10, 1'b1);
        wr(8'h14, 32'h8000);
        idle <= 1'b1;
        wait_clk(30);
        bus(1'b0, 8'h00, 32'h0);
        check(rdat > 32'h30, 1'b1);
        sleep <= 1'b1;
        idle <= 1'b0;
        wait_clk(4);
        wr(8'h00, 32'h0);
        wait_clk(20);
        rdc(8'h00, 32'h0);
        sleep <= 1'b0;
        wr(8'h14, 32'h0);
    endtask : t_idle

    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Main sequence after six reset cycles
    initial
    begin
        wait_clk(6);
        rst_i <= 1'b0;
        wait_clk(1);
        t_reset();
        t_wide();
        t_div();
        t_gate();
        t_ext();
        t_idle();
        stop_test();
    end

    // Watchdog well beyond the expected run of about five thousand cycles
    initial
    begin
        #1_000_000;
        n_fail++;
        stop_test();
    end
endmodule : test_pgt_timer
